// File: inc/pwcc_defs.vh
`ifndef PWCC_DEFS_VH
`define PWCC_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PWCC_OFS_CLKCTL   8'h00
`define PWCC_OFS_ANACTL   8'h04
`define PWCC_OFS_SVDCTL   8'h08
`define PWCC_OFS_ADCFLG   8'h0C
`define PWCC_OFS_STATUS   8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PWCC_CLK_SEL      0
`define PWCC_CLK_FOSC     1
`define PWCC_ANA_ADC      0
`define PWCC_ANA_MID0     1
`define PWCC_ANA_MID1     2
`define PWCC_ANA_VREF     3
`define PWCC_ANA_AMP0     4
`define PWCC_ANA_AMP1     5
`define PWCC_SVD_ON       0
`define PWCC_SVD_RES      1
`define PWCC_ADC_FLAG     0
`define PWCC_ADC_RST      1
`define PWCC_ST_FOSC_RDY  0
`define PWCC_ST_AMP0_RDY  1
`define PWCC_ST_AMP1_RDY  2
`define PWCC_ST_SVD_RDY   3
`define PWCC_ST_CPU_FAST  4

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define PWCC_CLK_RST      2'h0
`define PWCC_ANA_RST      6'h00
`define PWCC_CLK_W        2
`define PWCC_ANA_W        6
`define PWCC_ST_W         5
`define PWCC_CNT_W        20
`define PWCC_DATA_ZERO    32'h00000000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PWCC_PCLK_MHZ     125
`define PWCC_FOSC_STAB_US 5000
`define PWCC_AMP_STAB_US  3000
`define PWCC_SVD_STAB_US  100

`endif

// File: core/pwcc_settle_timer.v
`timescale 1ns/1ns
`include "pwcc_defs.vh"

module pwcc_settle_timer #(
    parameter [`PWCC_CNT_W-1:0] CYCLES = 20'h00001
) (
    // clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // control
    input  wire                   run,
    // status
    output reg                    done_r
);

    reg [`PWCC_CNT_W-1:0] cnt_r;

    // restarts from zero whenever the circuit is switched off
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= 20'h00000;
            done_r <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r  <= 20'h00000;
            done_r <= 1'b0;
        end
        else if (!done_r)
        begin
            cnt_r  <= cnt_r + 20'h00001;
            done_r <= (cnt_r + 20'h00001 >= CYCLES);
        end
    end

endmodule // pwcc_settle_timer

// File: core/pwcc_power_clock.v
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "pwcc_defs.vh"

// Behaviour
// - reset leaves cpu clock select at 0, slow oscillator drives the cpu
// - reset leaves fast oscillator enable at 0, oscillator stopped
// - reset clears adc power, reference and both mid-potential enables
// - reset clears both amplifier enables
// - reset clears the supply detector enable
// - detector result needs no extra delay when running from the slow clock
// - adc reset or power-off may set its flag; reading clears the flag
module pwcc_power_clock #(
    parameter FOSC_STAB_CYC = `PWCC_FOSC_STAB_US * `PWCC_PCLK_MHZ,
    parameter AMP_STAB_CYC  = `PWCC_AMP_STAB_US * `PWCC_PCLK_MHZ,
    parameter SVD_STAB_CYC  = `PWCC_SVD_STAB_US * `PWCC_PCLK_MHZ
) (
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // analog status inputs from detector and converter
    input  wire        supply_detect_level,
    input  wire        adc_irq_event,
    // clock controls
    output reg         cpu_clock_select,
    output reg         fast_osc_enable,
    // analog power controls
    output reg         adc_power_on,
    output reg         adc_reset_pulse,
    output reg         mid_potential_gen_on_0,
    output reg         mid_potential_gen_on_1,
    output reg         ref_voltage_gen_on,
    output reg         amplifier_on_0,
    output reg         amplifier_on_1,
    output reg         supply_detect_on,
    // flags
    output reg         supply_detect_result,
    output reg         adc_irq_flag
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire setup_ph  = psel & ~penable;
    wire access_ok = psel & penable & pready;
    wire wr_en     = access_ok & pwrite & ~pslverr;
    wire rd_en     = access_ok & ~pwrite & ~pslverr;
    // pslverr is registered alongside pready, so a refused write
    // never reaches the register processes through wr_en

    wire hit_clk = (paddr == `PWCC_OFS_CLKCTL);
    wire hit_ana = (paddr == `PWCC_OFS_ANACTL);
    wire hit_svd = (paddr == `PWCC_OFS_SVDCTL);
    wire hit_adc = (paddr == `PWCC_OFS_ADCFLG);
    wire hit_st  = (paddr == `PWCC_OFS_STATUS);
    wire mapped  = hit_clk | hit_ana | hit_svd | hit_adc | hit_st;

    // ------------------------------------------------------------
    // settle timers
    // ------------------------------------------------------------
    wire fosc_rdy;
    wire amp0_rdy;
    wire amp1_rdy;
    wire svd_rdy;

    // counts restart whenever an enable drops, so a quick off/on
    // never reports a half-settled circuit as ready

    // fast oscillator stabilisation window
    pwcc_settle_timer #(
        .CYCLES (FOSC_STAB_CYC[`PWCC_CNT_W-1:0])
    ) u_fosc_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (fast_osc_enable),
        .done_r  (fosc_rdy)
    );

    // amplifier 0 settling
    pwcc_settle_timer #(
        .CYCLES (AMP_STAB_CYC[`PWCC_CNT_W-1:0])
    ) u_amp0_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (amplifier_on_0),
        .done_r  (amp0_rdy)
    );

    // amplifier 1 settling
    pwcc_settle_timer #(
        .CYCLES (AMP_STAB_CYC[`PWCC_CNT_W-1:0])
    ) u_amp1_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (amplifier_on_1),
        .done_r  (amp1_rdy)
    );

    // detector response time
    pwcc_settle_timer #(
        .CYCLES (SVD_STAB_CYC[`PWCC_CNT_W-1:0])
    ) u_svd_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (supply_detect_on),
        .done_r  (svd_rdy)
    );

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    // readiness is only reported: nothing here stops an early
    // clock switch or amplifier use, that stays with software
    wire [`PWCC_ST_W-1:0] status_word;

    assign status_word[`PWCC_ST_FOSC_RDY] = fosc_rdy;
    assign status_word[`PWCC_ST_AMP0_RDY] = amp0_rdy;
    assign status_word[`PWCC_ST_AMP1_RDY] = amp1_rdy;
    assign status_word[`PWCC_ST_SVD_RDY]  = svd_rdy;
    assign status_word[`PWCC_ST_CPU_FAST] = cpu_clock_select;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    reg [31:0] rd_nxt;

    always @*
    begin
        // reserved bits read as zero
        rd_nxt = `PWCC_DATA_ZERO;
        if (hit_clk)
        begin
            rd_nxt[`PWCC_CLK_SEL]  = cpu_clock_select;
            rd_nxt[`PWCC_CLK_FOSC] = fast_osc_enable;
        end
        else if (hit_ana)
        begin
            rd_nxt[`PWCC_ANA_ADC]  = adc_power_on;
            rd_nxt[`PWCC_ANA_MID0] = mid_potential_gen_on_0;
            rd_nxt[`PWCC_ANA_MID1] = mid_potential_gen_on_1;
            rd_nxt[`PWCC_ANA_VREF] = ref_voltage_gen_on;
            rd_nxt[`PWCC_ANA_AMP0] = amplifier_on_0;
            rd_nxt[`PWCC_ANA_AMP1] = amplifier_on_1;
        end
        else if (hit_svd)
        begin
            rd_nxt[`PWCC_SVD_ON]  = supply_detect_on;
            rd_nxt[`PWCC_SVD_RES] = supply_detect_result;
        end
        else if (hit_adc)
        begin
            rd_nxt[`PWCC_ADC_FLAG] = adc_irq_flag;
        end
        else if (hit_st)
        begin
            rd_nxt[`PWCC_ST_W-1:0] = status_word;
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // no wait state: setup edge loads data and raises pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PWCC_DATA_ZERO;
        end
        else if (setup_ph)
        begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? `PWCC_DATA_ZERO : rd_nxt;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PWCC_DATA_ZERO;
        end
    end

    // ------------------------------------------------------------
    // clock control
    // ------------------------------------------------------------
    // slow clock, fast oscillator stopped
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clock_select <= 1'b0;
            fast_osc_enable  <= 1'b0;
        end
        else if (wr_en && hit_clk)
        begin
            // no guard against selecting a cold oscillator; glitch-free
            // handover of the cpu clock lives outside this block
            // bits steer the mux and oscillator directly
            cpu_clock_select <= pwdata[`PWCC_CLK_SEL];
            fast_osc_enable  <= pwdata[`PWCC_CLK_FOSC];
        end
    end

    // ------------------------------------------------------------
    // analog power control
    // ------------------------------------------------------------
    wire adc_off_evt = wr_en & hit_ana & adc_power_on & ~pwdata[`PWCC_ANA_ADC];
    wire adc_rst_evt = wr_en & hit_adc & pwdata[`PWCC_ADC_RST];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_power_on           <= 1'b0;
            mid_potential_gen_on_0 <= 1'b0;
            mid_potential_gen_on_1 <= 1'b0;
            ref_voltage_gen_on     <= 1'b0;
            amplifier_on_0         <= 1'b0;
            amplifier_on_1         <= 1'b0;
        end
        else if (wr_en && hit_ana)
        begin
            adc_power_on           <= pwdata[`PWCC_ANA_ADC];
            mid_potential_gen_on_0 <= pwdata[`PWCC_ANA_MID0];
            mid_potential_gen_on_1 <= pwdata[`PWCC_ANA_MID1];
            ref_voltage_gen_on     <= pwdata[`PWCC_ANA_VREF];
            amplifier_on_0         <= pwdata[`PWCC_ANA_AMP0];
            amplifier_on_1         <= pwdata[`PWCC_ANA_AMP1];
        end
    end

    // one-cycle converter reset strobe
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            adc_reset_pulse <= 1'b0;
        else
            adc_reset_pulse <= adc_rst_evt;
    end

    // ------------------------------------------------------------
    // converter interrupt factor flag
    // ------------------------------------------------------------
    wire flag_set = adc_irq_event | adc_off_evt | adc_rst_evt;
    wire flag_clr = rd_en & hit_adc;

    // set by converter event, reset or power-off, cleared by read; set wins
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            adc_irq_flag <= 1'b0;
        else if (flag_set)
            adc_irq_flag <= 1'b1;
        else if (flag_clr)
            adc_irq_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // supply voltage detector
    // ------------------------------------------------------------
    // detector off after reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_detect_on <= 1'b0;
        else if (wr_en && hit_svd)
            supply_detect_on <= pwdata[`PWCC_SVD_ON];
    end

    wire svd_off_evt = wr_en & hit_svd & supply_detect_on & ~pwdata[`PWCC_SVD_ON];

    // result frozen on the on-to-off write
    // the comparator is sampled at the turn-off edge whatever the
    // settle state; status bit tells software whether it was ready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_detect_result <= 1'b0;
        else if (svd_off_evt)
            supply_detect_result <= supply_detect_level;
    end

endmodule // pwcc_power_clock

// File: testbench/pwcc_power_clock_assertions.sv
`timescale 1ns/1ns
module pwcc_power_clock_checker (
    // apb side
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // controls and flags
    input wire        supply_detect_level,
    input wire        adc_irq_event,
    input wire        cpu_clock_select,
    input wire        fast_osc_enable,
    input wire        adc_power_on,
    input wire        adc_reset_pulse,
    input wire        mid_potential_gen_on_0,
    input wire        mid_potential_gen_on_1,
    input wire        ref_voltage_gen_on,
    input wire        amplifier_on_0,
    input wire        amplifier_on_1,
    input wire        supply_detect_on,
    input wire        supply_detect_result,
    input wire        adc_irq_flag
);
    // ----------------------------------------
    // access decode
    // ----------------------------------------
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h10);
    wire acc_w  = psel && penable && pready && pwrite;
    wire acc_r  = psel && penable && pready && !pwrite;
    wire [5:0] ana = {amplifier_on_1, amplifier_on_0, ref_voltage_gen_on,
                      mid_potential_gen_on_1, mid_potential_gen_on_0, adc_power_on};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access cycle");
    a_slverr_map: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong for address");
    a_clk_write: assert property (acc_w && paddr == 8'h00 |=>
        cpu_clock_select == $past(pwdata[0]) && fast_osc_enable == $past(pwdata[1]))
        else $error("clock controls do not follow write");
    a_clk_hold: assert property (!(acc_w && paddr == 8'h00) |=>
        $stable(cpu_clock_select) && $stable(fast_osc_enable))
        else $error("clock controls changed without write");
    a_ana_write: assert property (acc_w && paddr == 8'h04 |=> ana == $past(pwdata[5:0]))
        else $error("analog enables do not follow write");
    a_adc_off_flag: assert property (acc_w && paddr == 8'h04 && adc_power_on && !pwdata[0] |=> adc_irq_flag)
        else $error("converter power-off left flag clear");
    a_adc_rst_pulse: assert property (acc_w && paddr == 8'h0C && pwdata[1] |=> adc_reset_pulse ##1 !adc_reset_pulse)
        else $error("converter reset pulse wrong");
    a_detect_capture: assert property (acc_w && paddr == 8'h08 && supply_detect_on && !pwdata[0] |=>
        supply_detect_result == $past(supply_detect_level))
        else $error("detector result not captured");
    a_flag_event_set: assert property (adc_irq_event |=> adc_irq_flag)
        else $error("converter event left flag clear");
    a_flag_read_clr: assert property (acc_r && paddr == 8'h0C && !adc_irq_event |=> !adc_irq_flag)
        else $error("flag read did not clear it");
endmodule // pwcc_power_clock_checker

bind pwcc_power_clock pwcc_power_clock_checker u_pwcc_power_clock_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .supply_detect_level(supply_detect_level), .adc_irq_event(adc_irq_event),
    .cpu_clock_select(cpu_clock_select),
    .fast_osc_enable(fast_osc_enable), .adc_power_on(adc_power_on), .adc_reset_pulse(adc_reset_pulse),
    .mid_potential_gen_on_0(mid_potential_gen_on_0), .mid_potential_gen_on_1(mid_potential_gen_on_1),
    .ref_voltage_gen_on(ref_voltage_gen_on), .amplifier_on_0(amplifier_on_0), .amplifier_on_1(amplifier_on_1),
    .supply_detect_on(supply_detect_on), .supply_detect_result(supply_detect_result), .adc_irq_flag(adc_irq_flag));

// File: testbench/pwcc_power_clock_tb.sv
`timescale 1ns/1ns
module pwcc_power_clock_tb;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0, supply_detect_level = 0, adc_irq_event = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, cpu_clock_select, fast_osc_enable, adc_power_on, adc_reset_pulse;
    wire         mid0, mid1, vref, amp0, amp1, supply_detect_on, supply_detect_result, adc_irq_flag;
    wire  [5:0]  ana = {amp1, amp0, vref, mid1, mid0, adc_power_on};
    wire  [10:0] ctl = {adc_irq_flag, supply_detect_result, supply_detect_on, ana, fast_osc_enable, cpu_clock_select};
    integer      bad_count = 0, comparisons = 0, seed = 32'hB77F6B0D, i;
    logic [31:0] rd, d;
    logic [7:0]  ua;
    logic        er;

    pwcc_power_clock #(.FOSC_STAB_CYC(8), .AMP_STAB_CYC(6), .SVD_STAB_CYC(4)) u_pwcc_power_clock (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_detect_level(supply_detect_level), .adc_irq_event(adc_irq_event),
        .cpu_clock_select(cpu_clock_select), .fast_osc_enable(fast_osc_enable), .adc_power_on(adc_power_on),
        .adc_reset_pulse(adc_reset_pulse), .mid_potential_gen_on_0(mid0), .mid_potential_gen_on_1(mid1),
        .ref_voltage_gen_on(vref), .amplifier_on_0(amp0), .amplifier_on_1(amp1),
        .supply_detect_on(supply_detect_on), .supply_detect_result(supply_detect_result),
        .adc_irq_flag(adc_irq_flag));

    // ----------------------------------------
    // clock, watchdog, tasks
    // ----------------------------------------
    initial forever #4 pclk = ~pclk;
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        wrap_up;
    end

    task chk(input string nm, input [31:0] exp, input [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    // entered right after a rising edge, returns one idle edge after the access edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        integer n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            bad_count = bad_count + 1;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // one idle edge so register outputs are visible
    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        @(posedge pclk);
    endtask

    function logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] wd);
        exp_rd = (a == 8'h00) ? (wd & 32'h3) : (wd & 32'h3F);
    endfunction

    task wrap_up;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("ctl", 32'h0, ctl); // reset state
        for (i = 0; i < 5; i = i + 1)
        begin
            apb(1'b0, {i[5:0], 2'b00}, 32'h0);
            chk("rst_rd", 32'h0, rd); // reset readback
        end
        for (i = 0; i < 20; i = i + 1)
        begin
            d = $random(seed);
            // random writes keep the slow clock
            wr(8'h00, d & 32'h2);
            chk("clk", {d[1], 1'b0}, {fast_osc_enable, cpu_clock_select}); // select and enable
            wr(8'h04, d);
            chk("ana", d[5:0], ana); // analog enables
            apb(1'b0, 8'h00, 32'h0);
            chk("rd0", exp_rd(8'h00, d & 32'h2), rd); // readback
            apb(1'b0, 8'h04, 32'h0);
            chk("rd4", exp_rd(8'h04, d), rd); // readback
            ua = 8'h11 + 8'({$random(seed)} % 238);
            apb(1'b1, ua, ~d);
            chk("err", 32'h1, er);
            chk("held", {d[5:0], d[1], 1'b0}, ctl[7:0]); // unmapped write ignored
        end
        wr(8'h04, 32'h0);
        wr(8'h04, 32'h30);
        apb(1'b0, 8'h10, 32'h0);
        chk("amp_wait", 32'h0, rd[2:1]); // not settled yet
        repeat (8) @(posedge pclk);
        apb(1'b0, 8'h10, 32'h0);
        chk("amp_rdy", 32'h3, rd[2:1]); // both settled
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h2);
        apb(1'b0, 8'h10, 32'h0);
        chk("osc_wait", 32'h0, rd[0]); // start not yet stable
        repeat (10) @(posedge pclk);
        apb(1'b0, 8'h10, 32'h0);
        chk("osc_rdy", 32'h1, rd[4:0]); // oscillator stable
        wr(8'h00, 32'h3);
        apb(1'b0, 8'h10, 32'h0);
        chk("cpu_fast", 32'h1, rd[4]); // fast clock routed
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h0);
        chk("clk_off", 32'h0, {fast_osc_enable, cpu_clock_select}); // stopped
        for (i = 1; i >= 0; i = i - 1)
        begin
            supply_detect_level <= i[0];
            wr(8'h08, 32'h1);
            wr(8'h08, 32'h0);
            apb(1'b0, 8'h08, 32'h0);
            chk("svd", {i[0], 1'b0}, rd); // detector result
        end
        apb(1'b0, 8'h0C, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("flag_off", 32'h1, rd); // set by power-off
        apb(1'b0, 8'h0C, 32'h0);
        chk("flag_clr", 32'h0, rd); // read clears
        wr(8'h0C, 32'h2);
        chk("flag_rst", 32'h1, adc_irq_flag); // set by reset
        apb(1'b0, 8'h0C, 32'h0);
        adc_irq_event <= 1'b1;
        @(posedge pclk);
        adc_irq_event <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("flag_evt", 32'h1, adc_irq_flag);
        wr(8'h04, 32'h3F);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h2);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("ctl_rst", 32'h0, ctl); // second reset
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk("ana_rst", 32'h0, rd); // readback after reset
        wrap_up;
    end
endmodule // pwcc_power_clock_tb
